// [hw/fcs_config_seq.sv]
// Purpose: Configuration-load sequencing, passive and active serial
// Assumes: pins sampled by core_clk at 40 MHz; link clocks well below 20 MHz
// Notes:   Notes on behaviour list follows
// Notes on behaviour
// - Status low within 960 ns of request
// - Done low within 1440 ns of request
// - Status low pulse 268 us to 3000 us
// - Status released within 3000 us after request release
// - Passive serial data taken on rising clock
// - Flash command updates on falling clock edges
// - Flash read data captured at falling edges
// - Active serial reset timing equals passive serial
// - Oscillator init: user mode 175-830 us
// - User clock enabled late, then 600 clocks
// - Flash clock settings 12.5/25/50/100 only
// - Chained devices never use 100 MHz setting
// - Init takes 600 oscillator cycles, 10 MHz
// - User clock may clock initialization
// - Same bitstream size in both schemes
`timescale 1ns/1ps
module fcs_config_seq #(
	parameter int unsigned STATUS_MIN_CYC = fcs_pkg::STATUS_LOW_MIN_CYC,
	parameter int unsigned STATUS_MAX_CYC = fcs_pkg::STATUS_LOW_MAX_CYC,
	parameter int unsigned INIT_MIN_CYC   = fcs_pkg::INIT_MIN_CYC,
	parameter int unsigned INIT_MAX_CYC   = fcs_pkg::INIT_MAX_CYC,
	parameter int unsigned BITSTREAM_BITS = fcs_pkg::BITSTREAM_BITS_DEF
) (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic       reconfig_request_n,
	input  wire logic       active_serial_mode,
	input  wire logic       chain_member,
	input  wire logic       user_clock_option,
	input  wire logic [1:0] osc_setting,
	input  wire logic       status_n_in,
	output logic            status_n_out,
	output logic            status_n_oe,
	output logic            load_complete,
	input  wire logic       cfg_clock_in,
	output logic            cfg_clock_out,
	output logic            cfg_clock_oe,
	input  wire logic       ps_data_in,
	output logic            flash_cmd_out,
	output logic            flash_select_n,
	input  wire logic       flash_data_in,
	input  wire logic       user_init_clock,
	output logic            load_bit,
	output logic            load_bit_valid,
	output logic            user_mode
);
	localparam int AST_ST_MAX  = int'(fcs_pkg::REQ_TO_STATUS_CYC);
	localparam int AST_CD_MAX  = int'(fcs_pkg::REQ_TO_DONE_CYC);
	localparam int AST_UEN_MIN = int'(fcs_pkg::USER_EN_CYC + 2 * (fcs_pkg::INIT_CLOCKS - 1));

	logic [fcs_pkg::PIN_W-1:0]    pin_s1_q;
	logic [fcs_pkg::PIN_W-1:0]    pin_s2_q;
	logic                         cfg_clock_prev_q, uclk_prev_q;
	fcs_pkg::fcs_state_e          state_q, state_d;
	logic [31:0]                  cnt_q, cnt_d, tick_q, tick_d, bits_q, bits_d;
	logic [31:0]                  osc_q, osc_d, oe_len_q, rel_len_q;
	logic [7:0]                   div_q, div_d, half_c;
	logic [fcs_pkg::CMD_BITS-1:0] shreg_q, shreg_d;
	logic                         aclk_q, aclk_d, cmd_q, cmd_d, sel_n_q, sel_n_d, bit_q, bit_d;
	logic                         vld_q, vld_d, done_q, done_d, stat_oe_q, stat_oe_d;
	logic                         user_q, user_d, phase_q, phase_d, as_q, as_d, uopt_q, uopt_d;
	fcs_pkg::fcs_clk_set_e        set_q, set_d;
	logic                         req_s, stat_s, cfg_clock_rise, uclk_rise;
	logic                         osc_tick, as_edge, as_fall, last_bit, init_tick;

	// Two-stage synchronisers for every pin
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			pin_s1_q    <= '1;
			pin_s2_q    <= '1;
			cfg_clock_prev_q <= '1;
			uclk_prev_q <= '1;
		end else begin
			pin_s1_q    <= {osc_setting, user_clock_option, chain_member, active_serial_mode,
				user_init_clock, flash_data_in, ps_data_in, cfg_clock_in, status_n_in,
				reconfig_request_n};
			pin_s2_q    <= pin_s1_q;
			cfg_clock_prev_q <= pin_s2_q[fcs_pkg::PIN_CFG_CLOCK];
			uclk_prev_q <= pin_s2_q[fcs_pkg::PIN_UCLK];
		end
	end

	assign req_s     = pin_s2_q[fcs_pkg::PIN_REQ];
	assign stat_s    = pin_s2_q[fcs_pkg::PIN_STAT];
	assign cfg_clock_rise = pin_s2_q[fcs_pkg::PIN_CFG_CLOCK] && !cfg_clock_prev_q;
	assign uclk_rise = pin_s2_q[fcs_pkg::PIN_UCLK] && !uclk_prev_q;

	// Flash clock half period per setting
	always_comb begin
		case (set_q)
			fcs_pkg::FCS_SET_12M5: half_c = fcs_pkg::AS_HALF_12M5;
			fcs_pkg::FCS_SET_25M:  half_c = fcs_pkg::AS_HALF_25M;
			fcs_pkg::FCS_SET_50M:  half_c = fcs_pkg::AS_HALF_50M;
			default:               half_c = fcs_pkg::AS_HALF_100M;
		endcase
	end

	assign osc_tick  = (osc_q == 32'(fcs_pkg::OSC_DIV - 1));
	assign as_edge   = (div_q == half_c - 8'h01);
	assign as_fall   = as_edge && aclk_q;
	assign last_bit  = (bits_q == 32'(BITSTREAM_BITS - 1));
	assign init_tick = uopt_q ? (uclk_rise && cnt_q >= 32'(fcs_pkg::USER_EN_CYC))
		: osc_tick;

	always_comb begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		tick_d    = tick_q;
		bits_d    = bits_q;
		osc_d     = osc_tick ? '0 : osc_q + 32'h1;
		div_d     = div_q;
		shreg_d   = shreg_q;
		aclk_d    = aclk_q;
		cmd_d     = cmd_q;
		sel_n_d   = sel_n_q;
		bit_d     = bit_q;
		vld_d     = '0;
		done_d    = done_q;
		stat_oe_d = stat_oe_q;
		user_d    = user_q;
		phase_d   = phase_q;
		as_d      = as_q;
		uopt_d    = uopt_q;
		set_d     = set_q;
		if (!req_s && state_q != fcs_pkg::FCS_ST_CLEAR) begin
			state_d   = fcs_pkg::FCS_ST_CLEAR;
			cnt_d     = '0;
			stat_oe_d = '1;
			done_d    = '0;
			user_d    = '0;
			aclk_d    = '1;
			sel_n_d   = '1;
		end else begin
			case (state_q)
				fcs_pkg::FCS_ST_CLEAR: begin
					stat_oe_d = '1;
					done_d    = '0;
					user_d    = '0;
					aclk_d    = '1;
					sel_n_d   = '1;
					phase_d   = '0;
					bits_d    = '0;
					as_d      = pin_s2_q[fcs_pkg::PIN_AS];
					uopt_d    = pin_s2_q[fcs_pkg::PIN_UOPT];
					set_d     = fcs_pkg::fcs_clk_set_e'(pin_s2_q[fcs_pkg::PIN_SET +: 2]);
					if (pin_s2_q[fcs_pkg::PIN_CHAIN] && set_d == fcs_pkg::FCS_SET_100M) begin
						set_d = fcs_pkg::FCS_SET_50M;
					end
					if (cnt_q != 32'(STATUS_MIN_CYC)) begin
						cnt_d = cnt_q + 32'h1;
					end
					if (req_s && cnt_q == 32'(STATUS_MIN_CYC)) begin
						state_d   = fcs_pkg::FCS_ST_RELEASE;
						stat_oe_d = '0;
						cnt_d     = '0;
					end
				end
				fcs_pkg::FCS_ST_RELEASE: begin
					if (!stat_s) begin
						cnt_d = '0;
					end else if (!as_q) begin
						state_d = fcs_pkg::FCS_ST_LOAD;
					end else if (cnt_q == 32'(fcs_pkg::AS_LEAD_CYC - 1)) begin
						state_d = fcs_pkg::FCS_ST_LOAD;
						sel_n_d = '0;
						shreg_d = fcs_pkg::FLASH_SEQ;
						div_d   = '0;
					end else begin
						cnt_d = cnt_q + 32'h1;
					end
				end
				fcs_pkg::FCS_ST_LOAD: begin
					done_d = '0;
					if (!as_q) begin
						if (cfg_clock_rise) begin
							bit_d  = pin_s2_q[fcs_pkg::PIN_PSD];
							vld_d  = '1;
							bits_d = bits_q + 32'h1;
						end
					end else begin
						div_d = as_edge ? '0 : div_q + 8'h01;
						if (as_edge) begin
							aclk_d = !aclk_q;
						end
						if (as_fall && !phase_q) begin
							cmd_d   = shreg_q[fcs_pkg::CMD_BITS-1];
							shreg_d = {shreg_q[fcs_pkg::CMD_BITS-2:0], 1'b0};
							bits_d  = bits_q + 32'h1;
							if (bits_q == 32'(fcs_pkg::CMD_BITS - 1)) begin
								phase_d = '1;
								bits_d  = '0;
							end
						end else if (as_fall) begin
							bit_d  = pin_s2_q[fcs_pkg::PIN_FLD];
							vld_d  = '1;
							bits_d = bits_q + 32'h1;
						end
					end
					if (vld_d && last_bit) begin
						state_d = fcs_pkg::FCS_ST_INIT;
						done_d  = '1;
						cnt_d   = '0;
						tick_d  = '0;
						sel_n_d = '1;
					end
				end
				fcs_pkg::FCS_ST_INIT: begin
					cnt_d = cnt_q + 32'h1;
					aclk_d = '1;
					if (init_tick && tick_q != 32'(fcs_pkg::INIT_CLOCKS)) begin
						tick_d = tick_q + 32'h1;
					end
					if (tick_q == 32'(fcs_pkg::INIT_CLOCKS)
						&& (uopt_q || cnt_q >= 32'(INIT_MIN_CYC - 1))) begin
						state_d = fcs_pkg::FCS_ST_USER;
						user_d  = '1;
					end
				end
				fcs_pkg::FCS_ST_USER: begin
					user_d = '1;
				end
				default: begin
					state_d = fcs_pkg::FCS_ST_CLEAR;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			state_q   <= fcs_pkg::FCS_ST_CLEAR;
			cnt_q     <= '0;
			tick_q    <= '0;
			bits_q    <= '0;
			osc_q     <= '0;
			div_q     <= '0;
			shreg_q   <= '0;
			aclk_q    <= '1;
			cmd_q     <= '1;
			sel_n_q   <= '1;
			bit_q     <= '0;
			vld_q     <= '0;
			done_q    <= '0;
			stat_oe_q <= '1;
			user_q    <= '0;
			phase_q   <= '0;
			as_q      <= '0;
			uopt_q    <= '0;
			set_q     <= fcs_pkg::FCS_SET_12M5;
		end else begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			tick_q    <= tick_d;
			bits_q    <= bits_d;
			osc_q     <= osc_d;
			div_q     <= div_d;
			shreg_q   <= shreg_d;
			aclk_q    <= aclk_d;
			cmd_q     <= cmd_d;
			sel_n_q   <= sel_n_d;
			bit_q     <= bit_d;
			vld_q     <= vld_d;
			done_q    <= done_d;
			stat_oe_q <= stat_oe_d;
			user_q    <= user_d;
			phase_q   <= phase_d;
			as_q      <= as_d;
			uopt_q    <= uopt_d;
			set_q     <= set_d;
		end
	end

	assign status_n_out   = '0;
	assign status_n_oe    = stat_oe_q;
	assign load_complete  = done_q;
	assign cfg_clock_out  = aclk_q;
	assign cfg_clock_oe   = as_q;
	assign flash_cmd_out  = cmd_q;
	assign flash_select_n = sel_n_q;
	assign load_bit       = bit_q;
	assign load_bit_valid = vld_q;
	assign user_mode      = user_q;

	// Length of the status low pulse, total and after request release
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			oe_len_q  <= '0;
			rel_len_q <= '0;
		end else begin
			oe_len_q  <= stat_oe_q ? oe_len_q + 32'h1 : '0;
			rel_len_q <= (stat_oe_q && req_s) ? rel_len_q + 32'h1 : '0;
		end
	end

	AST_STATUS_FAST: assert property (@(posedge core_clk) disable iff (!reset_n)
		$fell(reconfig_request_n) |-> ##[1:AST_ST_MAX] status_n_oe)
		else $error("status not driven low in time");
	AST_DONE_FAST: assert property (@(posedge core_clk) disable iff (!reset_n)
		$fell(reconfig_request_n) |-> ##[1:AST_CD_MAX] !load_complete)
		else $error("done not low in time");
	AST_STATUS_MIN: assert property (@(posedge core_clk) disable iff (!reset_n)
		$fell(status_n_oe) |-> $past(oe_len_q) >= 32'(STATUS_MIN_CYC))
		else $error("status low pulse too short");
	AST_STATUS_REL: assert property (@(posedge core_clk) disable iff (!reset_n)
		rel_len_q <= 32'(STATUS_MAX_CYC))
		else $error("status held too long after request release");
	AST_AS_UPDATE: assert property (@(posedge core_clk) disable iff (!reset_n)
		$changed(flash_cmd_out) |-> $fell(cfg_clock_out) && !flash_select_n)
		else $error("flash command changed off a falling edge");
	AST_AS_CAPTURE: assert property (@(posedge core_clk) disable iff (!reset_n)
		load_bit_valid && as_q |-> $fell(cfg_clock_out) && $past(phase_q))
		else $error("flash data taken off a falling edge");
	AST_PS_CAPTURE: assert property (@(posedge core_clk) disable iff (!reset_n)
		load_bit_valid && !as_q |-> $past(cfg_clock_rise) && $past(state_q) == fcs_pkg::FCS_ST_LOAD)
		else $error("serial data taken without rising clock");
	AST_DONE_LOW: assert property (@(posedge core_clk) disable iff (!reset_n)
		$rose(load_complete) |-> load_bit_valid && $past(last_bit) && state_q == fcs_pkg::FCS_ST_INIT)
		else $error("done raised before bitstream complete");
	AST_INIT_OSC: assert property (@(posedge core_clk) disable iff (!reset_n)
		$rose(user_mode) && !uopt_q |-> $past(cnt_q) >= 32'(INIT_MIN_CYC - 1)
		&& $past(cnt_q) < 32'(INIT_MAX_CYC) && $past(tick_q) == 32'(fcs_pkg::INIT_CLOCKS))
		else $error("oscillator initialization time out of range");
	AST_INIT_USER: assert property (@(posedge core_clk) disable iff (!reset_n)
		$rose(user_mode) && uopt_q |-> $past(cnt_q) >= 32'(AST_UEN_MIN))
		else $error("user clock initialization too short");
	AST_NO_FAST_CHAIN: assert property (@(posedge core_clk) disable iff (!reset_n)
		state_q == fcs_pkg::FCS_ST_LOAD && as_q && $past(pin_s2_q[fcs_pkg::PIN_CHAIN], 2)
		&& $stable(set_q) |-> half_c != fcs_pkg::AS_HALF_100M || !$past(as_q, 1))
		else $error("fastest flash clock used in a chain");
endmodule // fcs_config_seq

// [inc/fcs_pkg.sv]
// Purpose: Shared constants for the configuration-load sequencer
// Assumes: core clock of 40 MHz
// Notes:   Timing figures kept in their own units, cycle counts derived
package fcs_pkg;
	localparam int unsigned CORE_KHZ           = 40000;
	localparam int unsigned CORE_PERIOD_PS     = 25000;
	localparam int unsigned PS_PER_NS          = 1000;
	localparam int unsigned PS_PER_US          = 1000000;

	localparam int unsigned REQ_TO_STATUS_NS   = 960;
	localparam int unsigned REQ_TO_DONE_NS     = 1440;
	localparam int unsigned STATUS_LOW_MIN_US  = 268;
	localparam int unsigned STATUS_LOW_MAX_US  = 3000;
	localparam int unsigned INIT_MIN_US        = 175;
	localparam int unsigned INIT_MAX_US        = 830;
	localparam int unsigned AS_LEAD_US         = 10;

	localparam int unsigned REQ_TO_STATUS_CYC  = REQ_TO_STATUS_NS * PS_PER_NS / CORE_PERIOD_PS;
	localparam int unsigned REQ_TO_DONE_CYC    = REQ_TO_DONE_NS * PS_PER_NS / CORE_PERIOD_PS;
	localparam int unsigned STATUS_LOW_MIN_CYC =
		(STATUS_LOW_MIN_US * PS_PER_US + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
	localparam int unsigned STATUS_LOW_MAX_CYC = STATUS_LOW_MAX_US * PS_PER_US / CORE_PERIOD_PS;
	localparam int unsigned INIT_MIN_CYC       =
		(INIT_MIN_US * PS_PER_US + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
	localparam int unsigned INIT_MAX_CYC       = INIT_MAX_US * PS_PER_US / CORE_PERIOD_PS;
	localparam int unsigned AS_LEAD_CYC        =
		(AS_LEAD_US * PS_PER_US + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;

	// Internal oscillator for initialization, at most 12.5 MHz
	localparam int unsigned OSC_MAX_KHZ        = 12500;
	localparam int unsigned OSC_DIV            = (CORE_KHZ + OSC_MAX_KHZ - 1) / OSC_MAX_KHZ;
	localparam int unsigned INIT_CLOCKS        = 600;
	localparam int unsigned USER_EN_PERIODS    = 4;

	// Half periods of the generated flash clock, in core cycles
	localparam logic [7:0]  AS_HALF_12M5       = 8'h18;
	localparam logic [7:0]  AS_HALF_25M        = 8'h0C;
	localparam logic [7:0]  AS_HALF_50M        = 8'h06;
	localparam logic [7:0]  AS_HALF_100M       = 8'h03;
	localparam int unsigned USER_EN_CYC        = USER_EN_PERIODS * 2 * int'(AS_HALF_12M5);

	localparam int unsigned CMD_BITS           = 32;
	localparam logic [31:0] FLASH_SEQ          = 32'h03000000;
	localparam int unsigned BITSTREAM_BITS_DEF = 1024;

	// Positions in the synchronised pin vector
	localparam int unsigned PIN_REQ            = 0;
	localparam int unsigned PIN_STAT           = 1;
	localparam int unsigned PIN_CFG_CLOCK           = 2;
	localparam int unsigned PIN_PSD            = 3;
	localparam int unsigned PIN_FLD            = 4;
	localparam int unsigned PIN_UCLK           = 5;
	localparam int unsigned PIN_AS             = 6;
	localparam int unsigned PIN_CHAIN          = 7;
	localparam int unsigned PIN_UOPT           = 8;
	localparam int unsigned PIN_SET            = 9;
	localparam int unsigned PIN_W              = 11;

	typedef enum logic [1:0] {
		FCS_SET_12M5 = 2'h0,
		FCS_SET_25M  = 2'h1,
		FCS_SET_50M  = 2'h2,
		FCS_SET_100M = 2'h3
	} fcs_clk_set_e;

	typedef enum logic [2:0] {
		FCS_ST_CLEAR   = 3'h0,
		FCS_ST_RELEASE = 3'h1,
		FCS_ST_LOAD    = 3'h3,
		FCS_ST_INIT    = 3'h2,
		FCS_ST_USER    = 3'h6
	} fcs_state_e;
endpackage

// [sim/fcs_flash_model.sv]
// Purpose: Behavioural serial flash answering one read per select
// Assumes: flash clock idles high, command bits change on its falls
// Notes:   Slow mode delays read data; use it only at the slowest clock setting
`timescale 1ns/1ps
module fcs_flash_model (
	input  wire logic        sck,
	input  wire logic        sel_n,
	input  wire logic        cmd,
	input  wire logic        slow,
	input  wire logic [15:0] image,
	output logic             dout,
	output logic [31:0]      cmd_seen
);
	int   rises;
	logic nb;
	initial begin
		rises = 0;
		dout = 1'b0;
		cmd_seen = '0;
	end
	// New read on each select
	always @(negedge sel_n) begin
		rises = 0;
		cmd_seen = '0;
	end
	// Released data line shows the inverse of its last value
	always @(posedge sel_n) begin
		dout = ~dout;
	end
	always @(posedge sck) begin
		if (!sel_n) begin
			rises = rises + 1;
			if (rises <= 32) begin
				cmd_seen = {cmd_seen[30:0], cmd};
			end
			if (rises >= 32 && rises < 48) begin
				nb = image[rises-32];
				#(slow ? 100 : 1);
				dout = nb;
			end else begin
				dout = ~dout;
			end
		end
	end
endmodule // fcs_flash_model

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the configuration-load sequencer
// Assumes: shortened counts passed as parameters
// Notes:   Bench is the passive serial host; flash model serves active serial
`timescale 1ns/1ps
module tb_top;
	localparam int SMIN = 50;
	localparam int SMAX = 200;
	localparam int IMIN = 3000;
	localparam int IMAX = 8000;
	localparam int BITS = 16;
	localparam int ULO  = fcs_pkg::USER_EN_CYC + 599 * 8 - 4;
	logic        core_clk, reset_n, req_n, as_mode, chain, uopt, hold_low, stat_out, stat_oe;
	logic        done, ck_in, ck_out, ps_d, cmd, sel_n, fl_d, uclk, lbit, lvalid, umode;
	logic        slow, prev_ck, ck_oe;
	logic [1:0]  setting;
	logic [15:0] image;
	logic [31:0] cmd_seen;
	wire         stat_in;
	logic        bq[$];
	logic        dq[$];
	int          failures, check_count, cycles, seed, n, last_per, since;

	// Open-drain status line with pull-up
	assign stat_in = ~((stat_oe & ~stat_out) | hold_low);

	fcs_config_seq #(
		.STATUS_MIN_CYC (SMIN),
		.STATUS_MAX_CYC (SMAX),
		.INIT_MIN_CYC   (IMIN),
		.INIT_MAX_CYC   (IMAX),
		.BITSTREAM_BITS (BITS)
	) DUT (
		.core_clk           (core_clk),
		.reset_n            (reset_n),
		.reconfig_request_n (req_n),
		.active_serial_mode (as_mode),
		.chain_member       (chain),
		.user_clock_option  (uopt),
		.osc_setting        (setting),
		.status_n_in        (stat_in),
		.status_n_out       (stat_out),
		.status_n_oe        (stat_oe),
		.load_complete      (done),
		.cfg_clock_in       (ck_in),
		.cfg_clock_out      (ck_out),
		.cfg_clock_oe       (ck_oe),
		.ps_data_in         (ps_d),
		.flash_cmd_out      (cmd),
		.flash_select_n     (sel_n),
		.flash_data_in      (fl_d),
		.user_init_clock    (uclk),
		.load_bit           (lbit),
		.load_bit_valid     (lvalid),
		.user_mode          (umode)
	);

	fcs_flash_model flash (
		.sck      (ck_out),
		.sel_n    (sel_n),
		.cmd      (cmd),
		.slow     (slow),
		.image    (image),
		.dout     (fl_d),
		.cmd_seen (cmd_seen)
	);

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		uclk = 1'b0;
		forever #100 uclk = ~uclk;
	end

	// Collects accepted bits and measures the flash clock period
	always @(negedge core_clk) begin
		if (lvalid === 1'b1) begin
			bq.push_back(lbit);
			dq.push_back(done);
		end
		if (sel_n === 1'b0 && prev_ck === 1'b1 && ck_out === 1'b0) begin
			last_per = since;
			since = 0;
		end
		since++;
		prev_ck = ck_out;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles >= 100000) begin
			failures++;
			close_out();
		end
	end

	task automatic close_out;
		$display("Checks %0d, failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_range(input string nm, input int g, input int lo, input int hi);
		check_count++;
		if (g < lo || g > hi) begin
			failures++;
			$display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask

	// Waits for status drive, done or user mode to reach a level
	task automatic wait_sig(input int which, input logic val, input int lim, output int cnt);
		logic v;
		cnt = 0;
		do begin
			@(negedge core_clk);
			cnt++;
			case (which)
				0: v = stat_oe;
				1: v = done;
				default: v = umode;
			endcase
		end while (v !== val && cnt < lim);
		chk_val("wait level", {31'h0, val}, {31'h0, v});
	endtask

	function automatic int half_of(input logic [1:0] s, input logic c);
		case (s)
			2'h0: return int'(fcs_pkg::AS_HALF_12M5);
			2'h1: return int'(fcs_pkg::AS_HALF_25M);
			2'h2: return int'(fcs_pkg::AS_HALF_50M);
			default: return c ? int'(fcs_pkg::AS_HALF_50M) : int'(fcs_pkg::AS_HALF_100M);
		endcase
	endfunction

	task automatic send_bit(input logic b);
		ps_d = b;
		ck_in = 1'b0;
		repeat (4) @(negedge core_clk);
		ck_in = 1'b1;
		repeat (4) @(negedge core_clk);
	endtask

	task automatic run_load(input logic a, input logic [1:0] s, input logic c, input logic u,
		input logic h);
		int ts;
		int td;
		ts = 0;
		td = 0;
		as_mode = a;
		setting = s;
		chain = c;
		uopt = u;
		slow = (s == 2'h0);
		image = 16'($random(seed));
		bq.delete();
		dq.delete();
		req_n = 1'b0;
		for (int i = 1; i <= 80; i++) begin
			@(negedge core_clk);
			if (ts == 0 && stat_oe === 1'b1) ts = i;
			if (td == 0 && done === 1'b0) td = i;
		end
		hold_low = h;
		req_n = 1'b1;
		chk_range("request to status low", ts, 1, 38);
		chk_range("request to done low", td, 1, 57);
		wait_sig(0, 1'b0, SMAX, n);
		chk_range("status release", n, 1, SMAX);
		chk_range("status low pulse", n + 80, SMIN, SMAX);
		if (h) begin
			repeat (SMAX) @(negedge core_clk);
			chk_val("done while held", 32'h0, {31'h0, done});
			hold_low = 1'b0;
		end
		repeat (400) @(negedge core_clk);
		if (!a) begin
			for (int i = 0; i < BITS; i++) send_bit(image[i]);
			ps_d = ~ps_d;
		end
		wait_sig(1, 1'b1, 4000, n);
		wait_sig(2, 1'b1, IMAX + 6000, n);
		if (u) chk_range("user clock init", n, ULO, ULO + 60);
		else chk_range("oscillator init", n, IMIN - 4, IMAX);
		chk_range("bit count", bq.size(), BITS, BITS);
		foreach (bq[i]) begin
			chk_val("load bit", {31'h0, image[i]}, {31'h0, bq[i]});
			chk_val("done with bit", {31'h0, i == BITS - 1}, {31'h0, dq[i]});
		end
		chk_val("clock drive", {31'h0, a}, {31'h0, ck_oe});
		if (a) begin
			chk_val("flash command", fcs_pkg::FLASH_SEQ, cmd_seen);
			chk_range("flash period", last_per, 2 * half_of(s, c), 2 * half_of(s, c));
		end
	endtask

	initial begin
		seed = 73759;
		reset_n = 1'b0;
		req_n = 1'b1;
		as_mode = 1'b0;
		chain = 1'b0;
		uopt = 1'b0;
		setting = 2'h0;
		hold_low = 1'b0;
		ck_in = 1'b0;
		ps_d = 1'b0;
		slow = 1'b0;
		image = 16'h0;
		prev_ck = 1'b1;
		failures = 0;
		check_count = 0;
		cycles = 0;
		since = 0;
		last_per = 0;
		repeat (16) @(negedge core_clk);
		chk_val("status in reset", 32'h1, {31'h0, stat_oe});
		chk_val("done in reset", 32'h0, {31'h0, done});
		reset_n = 1'b1;
		wait_sig(0, 1'b0, SMAX, n);
		chk_range("status after reset", n, SMIN - 1, SMAX);
		run_load(1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
		run_load(1'b0, 2'h1, 1'b1, 1'b1, 1'b1);
		for (int s = 0; s < 4; s++) begin
			run_load(1'b1, s[1:0], 1'b0, s == 1, 1'b0);
		end
		run_load(1'b1, 2'h3, 1'b1, 1'b0, 1'b0);
		run_load(1'b1, 2'h2, 1'b1, 1'b0, 1'b1);
		close_out();
	end
endmodule // tb_top
